//--- common/dgcs_pkg.sv
// package for the global command and status block of the serial dma controller
// assumes a simple word-wide register port driven by the pci target logic
package dgcs_pkg;
  // register offsets, byte addresses
  localparam logic [7:0] GCMD_OFS = 8'h00;
  localparam logic [7:0] GSTAT_OFS = 8'h04;
  localparam logic [7:0] GLOBAL_MODE_OFS = 8'h08;
  // command register fields
  localparam int CMD_AR_BIT = 0;
  localparam int CMD_IMASK_BIT = 9;
  localparam int CMD_POLL_LO = 10;
  localparam int CMD_CFGQ_BIT = 21;
  localparam int CMD_TXQ_LO = 24;
  localparam int CMD_RXQ_LO = 28;
  localparam logic IMASK_RESET = 1'b1;
  // status register fields
  localparam int ST_ACK_BIT = 0;
  localparam int ST_FAIL_BIT = 1;
  localparam int ST_CFGQ_BIT = 21;
  localparam int ST_TXQ_LO = 24;
  localparam int ST_RXQ_LO = 28;
  localparam int NUM_CH = 4;
  // per-channel transmit chain states
  typedef enum logic [1:0] {
    TX_RUN = 2'b00,
    TX_HELD = 2'b01,
    TX_REFETCH = 2'b10
  } dgcs_tx_state_t;
  // register port request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dgcs_req_t;
  // hardware events into the status register
  typedef struct packed {
    logic [NUM_CH-1:0] rxVec;
    logic [NUM_CH-1:0] txVec;
    logic cfgVec;
    logic arOk;
    logic arFail;
  } dgcs_evt_t;
endpackage

//--- logic/dgcs_tx_chan.sv
// one transmit channel's hold-flag chain controller
// assumes the descriptor fetch engine answers fetches with hold flag and done
`timescale 1ns/1ps
`default_nettype none
module dgcs_tx_chan (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chainMode,
  input wire logic pollReq,
  input wire logic holdSeen,
  input wire logic fetchDone,
  input wire logic fetchHold,
  output logic fetchReq,
  output logic advance,
  output logic held
);
  import dgcs_pkg::*;
  dgcs_tx_state_t state_q, state_d;

  // next state: held stops chain, poll re-fetches words 0 and 1
  always_comb begin
    state_d = state_q;
    case (state_q)
      TX_RUN: begin
        if (holdSeen && !chainMode) state_d = TX_HELD; // [R2] [R15]
      end
      TX_HELD: begin
        if (pollReq && !chainMode) state_d = TX_REFETCH; // [R3] [R1]
      end
      TX_REFETCH: begin
        if (fetchDone) state_d = fetchHold ? TX_HELD : TX_RUN; // [R4]
      end
      default: state_d = TX_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) state_q <= TX_RUN;
    else state_q <= state_d;
  end

  // poll outside held state falls through with no effect
  assign fetchReq = (state_q == TX_REFETCH); // [R5]
  assign advance = (state_q == TX_REFETCH) && fetchDone && !fetchHold;
  assign held = (state_q == TX_HELD);

  AST_HOLD_STOPS: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
    (state_q == TX_RUN && holdSeen && !chainMode) |=> held)
    else $error("channel did not stop on hold");
  AST_POLL_REFETCH: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
    (held && pollReq && !chainMode) |=> fetchReq)
    else $error("poll did not re-fetch");
  AST_POLL_IGNORED: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
    (state_q == TX_RUN && pollReq && !holdSeen) |=> !fetchReq)
    else $error("poll acted outside held state");
  AST_POLL_MODE: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    (held && chainMode) |=> held)
    else $error("poll acted in address chain mode");
endmodule // dgcs_tx_chan
`default_nettype wire

//--- logic/dgcs_status.sv
// sticky write-one-to-clear status bits and interrupt summary
// assumes events are single-cycle pulses on ref_clk
`timescale 1ns/1ps
`default_nettype none
module dgcs_status (
  input wire logic ref_clk,
  input wire logic rst,
  input wire dgcs_pkg::dgcs_evt_t evt,
  input wire logic clrWr,
  input wire logic [31:0] clrMask,
  output logic [31:0] statusWord,
  output logic anyInd
);
  import dgcs_pkg::*;
  logic [31:0] stat_q, stat_d;
  logic [31:0] setV;

  // event mapping to status positions
  always_comb begin
    setV = 32'h0;
    setV[ST_RXQ_LO +: NUM_CH] = evt.rxVec; // [R14]
    setV[ST_TXQ_LO +: NUM_CH] = evt.txVec; // [R14]
    setV[ST_CFGQ_BIT] = evt.cfgVec; // [R16]
    setV[ST_ACK_BIT] = evt.arOk; // [R17]
    setV[ST_FAIL_BIT] = evt.arFail; // [R18]
  end

  // set wins over a same-cycle clear so no event is lost
  always_comb begin
    stat_d = stat_q & ~(clrWr ? clrMask : 32'h0); // [R12]
    stat_d = stat_d | setV;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) stat_q <= 32'h0;
    else stat_q <= stat_d;
  end

  assign statusWord = stat_q; // [R10]
  // queue indications only; result bits 1:0 feed the line through the config queue
  assign anyInd = |stat_q[31:ST_CFGQ_BIT]; // [R13]

  AST_W1C: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
    (clrWr && clrMask[ST_RXQ_LO] && !evt.rxVec[0]) |=> !stat_q[ST_RXQ_LO])
    else $error("write one did not clear");
  AST_W0KEEP: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
    (stat_q[ST_TXQ_LO] && !(clrWr && clrMask[ST_TXQ_LO])) |=> stat_q[ST_TXQ_LO])
    else $error("indication lost without clear");
  AST_SET: assert property (@(posedge ref_clk) disable iff (rst) // [R16]
    evt.cfgVec |=> stat_q[ST_CFGQ_BIT])
    else $error("config queue indication not set");
endmodule // dgcs_status
`default_nettype wire

//--- logic/dgcs_top.sv
// global command, mode and status registers of the four-channel serial dma
// assumes one-cycle register requests from the pci target, reads answered from a register one cycle later
//
// Overview of operation
// [R1] poll self-clears, works only in hold mode
// [R2] no poll: channel stops on hold flag
// [R3] poll while held re-fetches descriptor words
// [R4] hold cleared on re-fetch: go next
// [R5] poll outside held state is ignored
// [R6] poll bits 13:10 per channel, reset zero
// [R7] action irq mask bit 9 resets one
// [R8] action request bit applies config bits
// [R9] command bits 8:1 read zero
// [R10] status shows action result and queues
// [R11] nine vector queues: rx, tx, config
// [R12] write one clears, zero keeps
// [R13] interrupt line while any indication set
// [R14] rx 31:28, tx 27:24 set on vectors
// [R15] mode bit selects hold or address end
// [R16] config queue bit 21 sticky, w1c
// [R17] status bit 0 on action success
// [R18] status bit 1 on action failure
// [R19] self-clearing bits read zero after acceptance
`timescale 1ns/1ps
`default_nettype none
module dgcs_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire dgcs_pkg::dgcs_req_t req,
  input wire logic reqValid,
  output logic [31:0] rdata,
  input wire logic [dgcs_pkg::NUM_CH-1:0] holdSeen,
  input wire logic [dgcs_pkg::NUM_CH-1:0] fetchDone,
  input wire logic [dgcs_pkg::NUM_CH-1:0] fetchHold,
  input wire logic [dgcs_pkg::NUM_CH-1:0] rxVecWr,
  input wire logic [dgcs_pkg::NUM_CH-1:0] txVecWr,
  input wire logic arDone,
  input wire logic arFailed,
  output logic [dgcs_pkg::NUM_CH-1:0] fetchReq,
  output logic [dgcs_pkg::NUM_CH-1:0] advance,
  output logic [dgcs_pkg::NUM_CH-1:0] heldOut,
  output logic arStart,
  output logic [8:0] queueCfgCmd,
  output logic chainModeOut,
  output logic intaN
);
  import dgcs_pkg::*;
  logic wrCmd, wrStat, wrMode;
  logic [31:0] cmdWord, statusWord;
  logic anyInd;
  dgcs_evt_t evt;
  logic [NUM_CH-1:0] pollPulse, fetchReqW, advanceW, heldW;
  // command state
  logic [3:0] rxq_q, rxq_d, txq_q, txq_d;
  logic cfgq_q, cfgq_d, imask_q, imask_d, mode_q, mode_d;
  logic [NUM_CH-1:0] poll_q, poll_d;
  logic ar_q, ar_d, arBusy_q, arBusy_d;
  logic [31:0] rdata_q, rdata_d;
  logic arStart_q, arStart_d, inta_q, inta_d;
  logic [NUM_CH-1:0] fetchReq_q, advance_q, held_q;

  // address decode of the register port
  assign wrCmd = reqValid && req.wr && (req.addr == GCMD_OFS);
  assign wrStat = reqValid && req.wr && (req.addr == GSTAT_OFS);
  assign wrMode = reqValid && req.wr && (req.addr == GLOBAL_MODE_OFS);

  // command register next values; self-clearing bits live one cycle
  always_comb begin
    rxq_d = rxq_q;
    txq_d = txq_q;
    cfgq_d = cfgq_q;
    imask_d = imask_q;
    mode_d = mode_q;
    poll_d = '0; // [R1] [R19]
    ar_d = 1'b0; // [R19]
    arBusy_d = arBusy_q;
    if (wrCmd) begin
      rxq_d = req.wdata[CMD_RXQ_LO +: 4];
      txq_d = req.wdata[CMD_TXQ_LO +: 4];
      cfgq_d = req.wdata[CMD_CFGQ_BIT];
      imask_d = req.wdata[CMD_IMASK_BIT]; // [R7]
      poll_d = req.wdata[CMD_POLL_LO +: NUM_CH]; // [R6]
      ar_d = req.wdata[CMD_AR_BIT] && !arBusy_q && !ar_q; // [R8]
    end
    if (wrMode) mode_d = req.wdata[0]; // [R15]
    if (ar_q) arBusy_d = 1'b1;
    else if (arDone) arBusy_d = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxq_q <= 4'h0;
      txq_q <= 4'h0;
      cfgq_q <= 1'b0;
      imask_q <= IMASK_RESET;
      mode_q <= 1'b0;
      poll_q <= '0;
      ar_q <= 1'b0;
      arBusy_q <= 1'b0;
    end else begin
      rxq_q <= rxq_d;
      txq_q <= txq_d;
      cfgq_q <= cfgq_d;
      imask_q <= imask_d;
      mode_q <= mode_d;
      poll_q <= poll_d;
      ar_q <= ar_d;
      arBusy_q <= arBusy_d;
    end
  end

  assign pollPulse = poll_q;

  // one hold-flag controller per transmit channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : gTx
      dgcs_tx_chan uChan (
        .ref_clk(ref_clk),
        .rst(rst),
        .chainMode(mode_q),
        .pollReq(pollPulse[gi]),
        .holdSeen(holdSeen[gi]),
        .fetchDone(fetchDone[gi]),
        .fetchHold(fetchHold[gi]),
        .fetchReq(fetchReqW[gi]),
        .advance(advanceW[gi]),
        .held(heldW[gi])
      );
    end
  endgenerate

  // result vectors land in the config queue unless masked
  always_comb begin
    evt.rxVec = rxVecWr; // [R11] [R14]
    evt.txVec = txVecWr; // [R11] [R14]
    evt.cfgVec = arBusy_q && arDone && !imask_q; // [R11] [R16]
    evt.arOk = arBusy_q && arDone && !arFailed; // [R17]
    evt.arFail = arBusy_q && arDone && arFailed; // [R18]
  end

  dgcs_status uStat (
    .ref_clk(ref_clk),
    .rst(rst),
    .evt(evt),
    .clrWr(wrStat),
    .clrMask(req.wdata),
    .statusWord(statusWord),
    .anyInd(anyInd)
  );

  // command readback; reserved bits show zero, self-clearing bits show one only in the cycle they live
  always_comb begin
    cmdWord = 32'h0; // [R9]
    cmdWord[CMD_RXQ_LO +: 4] = rxq_q;
    cmdWord[CMD_TXQ_LO +: 4] = txq_q;
    cmdWord[CMD_CFGQ_BIT] = cfgq_q;
    cmdWord[CMD_POLL_LO +: NUM_CH] = poll_q; // [R19]
    cmdWord[CMD_IMASK_BIT] = imask_q;
    cmdWord[CMD_AR_BIT] = ar_q; // [R19]
  end

  // output registers
  always_comb begin
    rdata_d = 32'h0;
    if (reqValid && !req.wr) begin
      case (req.addr)
        GCMD_OFS: rdata_d = cmdWord;
        GSTAT_OFS: rdata_d = statusWord; // [R10]
        GLOBAL_MODE_OFS: rdata_d = {31'h0, mode_q};
        default: rdata_d = 32'h0;
      endcase
    end
    arStart_d = ar_q; // [R8]
    inta_d = !anyInd; // [R13]
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 32'h0;
      arStart_q <= 1'b0;
      inta_q <= 1'b1;
      fetchReq_q <= '0;
      advance_q <= '0;
      held_q <= '0;
    end else begin
      rdata_q <= rdata_d;
      arStart_q <= arStart_d;
      inta_q <= inta_d;
      fetchReq_q <= fetchReqW;
      advance_q <= advanceW;
      held_q <= heldW;
    end
  end

  assign rdata = rdata_q;
  assign arStart = arStart_q;
  assign queueCfgCmd = {rxq_q, txq_q, cfgq_q};
  assign chainModeOut = mode_q;
  assign intaN = inta_q;
  assign fetchReq = fetchReq_q;
  assign advance = advance_q;
  assign heldOut = held_q;

  // action request bit and its start pulse each live one cycle
  AST_AR_SELFCLR: assert property (@(posedge ref_clk) disable iff (rst) // [R19]
    ar_q |=> !ar_q)
    else $error("action request bit did not self-clear");
  AST_AR_START: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    (wrCmd && req.wdata[CMD_AR_BIT] && !arBusy_q && !ar_q) |=> ##1 arStart)
    else $error("action request not started");
  AST_AR_PULSE: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    arStart |=> !arStart)
    else $error("action start pulse longer than one cycle");
  AST_START_BUSY: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    arStart |-> arBusy_q)
    else $error("action started without busy tracking");
  // a request while one is in flight is dropped, not queued
  AST_AR_DROP: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    (wrCmd && req.wdata[CMD_AR_BIT] && (arBusy_q || ar_q)) |=> !ar_q)
    else $error("action request accepted while busy");

  // interrupt line follows the queue indications only
  AST_INTA: assert property (@(posedge ref_clk) disable iff (rst) // [R13]
    (|statusWord[31:ST_CFGQ_BIT]) |=> !intaN)
    else $error("interrupt line not asserted");
  AST_INTA_OFF: assert property (@(posedge ref_clk) disable iff (rst) // [R13]
    (statusWord[31:ST_CFGQ_BIT] == 11'h0) |=> intaN)
    else $error("interrupt line held without indication");

  // command readback and reserved bits
  AST_RSVD: assert property (@(posedge ref_clk) disable iff (rst) // [R9]
    cmdWord[8:1] == 8'h00)
    else $error("reserved command bits not zero");
  AST_RD_RSVD: assert property (@(posedge ref_clk) disable iff (rst) // [R9]
    (reqValid && !req.wr && req.addr == GCMD_OFS) |=> (rdata[8:1] == 8'h00))
    else $error("reserved command bits read nonzero");
  AST_RD_ARZERO: assert property (@(posedge ref_clk) disable iff (rst) // [R19]
    (reqValid && !req.wr && req.addr == GCMD_OFS && !ar_q) |=> !rdata[CMD_AR_BIT])
    else $error("accepted action request still reads one");
  AST_RD_STRSVD: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
    (reqValid && !req.wr && req.addr == GSTAT_OFS) |=> (rdata[23:22] == 2'b00 && rdata[20:2] == 19'h0))
    else $error("reserved status bits read nonzero");
  // read port is quiet unless a read was taken
  AST_RD_IDLE: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
    !(reqValid && !req.wr) |=> (rdata == 32'h0))
    else $error("read data not zero outside a read");

  // poll bits live one cycle and only follow a command write
  AST_POLL_SELFCLR: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    !wrCmd |=> (poll_q == '0))
    else $error("poll bit set without a command write");
  AST_POLL_LOAD: assert property (@(posedge ref_clk) disable iff (rst) // [R6]
    (wrCmd && req.wdata[CMD_POLL_LO]) |=> poll_q[0])
    else $error("poll bit of channel zero not taken");

  // mask and queue configure bits follow each command write
  AST_IMASK_SET: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
    (wrCmd && req.wdata[CMD_IMASK_BIT]) |=> imask_q)
    else $error("mask bit not set by write");
  AST_IMASK_CLR: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
    (wrCmd && !req.wdata[CMD_IMASK_BIT]) |=> !imask_q)
    else $error("mask bit not cleared by write");
  AST_QCFG_RX: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    (wrCmd && req.wdata[CMD_RXQ_LO]) |=> queueCfgCmd[5])
    else $error("receive queue configure bit not held");
  AST_QCFG_TX: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    (wrCmd && req.wdata[CMD_TXQ_LO]) |=> queueCfgCmd[1])
    else $error("transmit queue configure bit not held");
  AST_QCFG_CFG: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    (wrCmd && req.wdata[CMD_CFGQ_BIT]) |=> queueCfgCmd[0])
    else $error("config queue configure bit not held");

  // mode bit drives the chain end select
  AST_MODE_SET: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
    (wrMode && req.wdata[0]) |=> chainModeOut)
    else $error("mode bit not set by write");
  AST_MODE_CLR: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
    (wrMode && !req.wdata[0]) |=> !chainModeOut)
    else $error("mode bit not cleared by write");

  // hardware events land in the sticky status bits
  AST_RX_SET: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
    (rxVecWr != '0) |=> ((statusWord[ST_RXQ_LO +: NUM_CH] & $past(rxVecWr)) == $past(rxVecWr)))
    else $error("receive queue indication not set");
  AST_TX_SET: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
    (txVecWr != '0) |=> ((statusWord[ST_TXQ_LO +: NUM_CH] & $past(txVecWr)) == $past(txVecWr)))
    else $error("transmit queue indication not set");
  AST_OK_SET: assert property (@(posedge ref_clk) disable iff (rst) // [R17]
    evt.arOk |=> statusWord[ST_ACK_BIT])
    else $error("action success bit not set");
  AST_FAIL_SET: assert property (@(posedge ref_clk) disable iff (rst) // [R18]
    evt.arFail |=> statusWord[ST_FAIL_BIT])
    else $error("action failure bit not set");
  AST_CFG_RESULT: assert property (@(posedge ref_clk) disable iff (rst) // [R16]
    (arBusy_q && arDone && !imask_q) |=> statusWord[ST_CFGQ_BIT])
    else $error("unmasked action result did not reach config queue");
  // a stray result line must not raise the config indication
  AST_CFG_QUIET: assert property (@(posedge ref_clk) disable iff (rst) // [R16]
    (!statusWord[ST_CFGQ_BIT] && !(arBusy_q && arDone)) |=> !statusWord[ST_CFGQ_BIT])
    else $error("config indication set without an action result");
endmodule // dgcs_top
`default_nettype wire

//--- tb/dgcs_engine_model.sv
// engine-side stand-in: answers descriptor re-fetches and action requests
// assumes the block's outputs are registered on ref_clk
`timescale 1ns/1ps
`default_nettype none
module dgcs_engine_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] fetchReq,
  input wire logic arStart,
  input wire logic [3:0] holdVal,
  input wire logic failVal,
  input wire logic [1:0] lat,
  output logic [3:0] fetchDone,
  output logic [3:0] fetchHold,
  output logic arDone,
  output logic arFailed
);
  int fc[4];
  int ac;
  // answer after lat extra cycles; result lines carry junk outside a done pulse
  always @(posedge ref_clk) begin
    fetchDone <= '0;
    fetchHold <= ~holdVal;
    arDone <= 1'b0;
    arFailed <= ~failVal;
    if (rst) begin
      ac <= 0;
      fc <= '{default: 0};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!fetchReq[i] || fetchDone[i]) fc[i] <= 0;
        else if (fc[i] >= int'(lat)) begin
          fetchDone[i] <= 1'b1;
          fetchHold[i] <= holdVal[i];
          fc[i] <= 0;
        end else fc[i] <= fc[i] + 1;
      end
      if (arStart) ac <= int'(lat) + 1;
      else if (ac == 1) begin
        arDone <= 1'b1;
        arFailed <= failVal;
        ac <= 0;
      end else if (ac > 1) ac <= ac - 1;
    end
  end
endmodule // dgcs_engine_model
`default_nettype wire

//--- tb/dgcs_top_test.sv
// self-checking bench for the global command and status block
// assumes the engine stand-in answers fetches and action requests
`timescale 1ns/1ps
`default_nettype none
module dgcs_top_test;
  import dgcs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  dgcs_req_t req = '0;
  logic reqValid = 1'b0;
  logic [3:0] holdSeen = '0, rxVecWr = '0, txVecWr = '0, holdVal = '0;
  logic failVal = 1'b0;
  logic [1:0] lat = '0;
  logic [31:0] rdata, stat = '0, cmd = 32'h0000_0200, w, m, pol;
  logic [3:0] fetchDone, fetchHold, fetchReq, advance, heldOut;
  logic arDone, arFailed, arStart, chainModeOut, intaN;
  logic [8:0] queueCfgCmd;
  int nMismatch = 0, checkCount = 0, cyc = 0, arN = 0, advN[4], fetN[4], n, a, f;
  always #2.5 ref_clk = ~ref_clk;
  dgcs_top dgcs_top_i (.ref_clk, .rst, .req, .reqValid, .rdata, .holdSeen, .fetchDone, .fetchHold,
    .rxVecWr, .txVecWr, .arDone, .arFailed, .fetchReq, .advance, .heldOut(heldOut), .arStart,
    .queueCfgCmd, .chainModeOut, .intaN);
  dgcs_engine_model dgcs_engine_model_i (.ref_clk, .rst, .fetchReq, .arStart, .holdVal, .failVal,
    .lat, .fetchDone, .fetchHold, .arDone, .arFailed);
  // pulses are counted so a one-cycle output is never missed
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (arStart) arN <= arN + 1;
    for (int i = 0; i < 4; i++) begin
      if (advance[i]) advN[i] <= advN[i] + 1;
      if (fetchReq[i]) fetN[i] <= fetN[i] + 1;
    end
  end
  always @(posedge ref_clk) if (cyc == 6000) begin
    nMismatch = nMismatch + 1;
    finalReport();
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one register access, held exactly one cycle
  task automatic acc(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{wr: wr, addr: ad, wdata: d};
    reqValid <= 1'b1;
    @(posedge ref_clk);
    reqValid <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string nm);
    acc(1'b0, ad, '0);
    #1 chk(nm, e, rdata);
  endtask
  task automatic rdStat();
    rd(GSTAT_OFS, stat, "status");
    chk("intaN", {31'h0, stat[31:21] == 11'h0}, intaN);
  endtask
  task automatic finalReport();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h0f8b6b6d));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(GCMD_OFS, cmd, "cmd");
    rdStat();
    rd(GLOBAL_MODE_OFS, '0, "mode");
    chk("chainMode", 0, chainModeOut);
    rd(8'h0C, '0, "unmapped");
    // random command word without self-clearing bits; reserved bits must read zero
    w = $urandom & 32'hFFFF_C3FE;
    acc(1'b1, GCMD_OFS, w);
    cmd = w & 32'hFF20_0200;
    rd(GCMD_OFS, cmd, "cmd");
    chk("queueCfg", {23'h0, cmd[31:24], cmd[21]}, queueCfgCmd);
    $display("reset and command test done");
    // success, failure, then success with the result vector masked
    for (int k = 0; k < 3; k++) begin
      failVal <= (k == 1);
      lat <= 2'($urandom);
      cmd[9] = (k == 2);
      n = arN;
      acc(1'b1, GCMD_OFS, cmd | 32'h1);
      rd(GCMD_OFS, cmd, "cmd");
      repeat (10) @(posedge ref_clk);
      chk("arStart", n + 1, arN);
      stat = stat | ((k == 1) ? 32'h2 : 32'h1) | ((k == 2) ? 32'h0 : 32'h0020_0000);
      rdStat();
      acc(1'b1, GSTAT_OFS, stat);
      stat = '0;
      rdStat();
    end
    $display("action request test done");
    // random queue vectors, then random write-one-to-clear masks
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      rxVecWr <= 4'($urandom);
      txVecWr <= 4'($urandom);
      @(posedge ref_clk);
      stat = stat | {rxVecWr, txVecWr, 24'h0};
      rxVecWr <= '0;
      txVecWr <= '0;
      rdStat();
      m = $urandom;
      acc(1'b1, GSTAT_OFS, m);
      stat = stat & ~m;
      rdStat();
    end
    $display("queue indication test done");
    for (int i = 0; i < 4; i++) begin
      a = advN[i];
      f = fetN[i];
      pol = cmd | (32'h0000_0400 << i);
      acc(1'b1, GCMD_OFS, pol);
      repeat (8) @(posedge ref_clk);
      chk("fetchIdle", f, fetN[i]);
      holdSeen[i] <= 1'b1;
      @(posedge ref_clk);
      holdSeen <= '0;
      repeat (3) @(posedge ref_clk);
      chk("held", 1, heldOut[i]);
      holdVal[i] <= 1'b1;
      acc(1'b1, GCMD_OFS, pol);
      repeat (12) @(posedge ref_clk);
      chk("refetch", 1, fetN[i] != f);
      chk("stillHeld", {31'h0, heldOut[i]} + advN[i] - a, 1);
      holdVal[i] <= 1'b0;
      acc(1'b1, GLOBAL_MODE_OFS, 32'hFFFF_FFFF);
      rd(GLOBAL_MODE_OFS, 1, "mode");
      chk("chainMode", 1, chainModeOut);
      f = fetN[i];
      acc(1'b1, GCMD_OFS, pol);
      repeat (12) @(posedge ref_clk);
      chk("modeIgnore", f, fetN[i]);
      acc(1'b1, GLOBAL_MODE_OFS, '0);
      acc(1'b1, GCMD_OFS, pol);
      repeat (12) @(posedge ref_clk);
      chk("advance", a + 1, advN[i]);
      chk("released", 0, heldOut[i]);
      rd(GCMD_OFS, cmd, "cmd");
    end
    $display("poll test done");
    finalReport();
  end
endmodule // dgcs_top_test
`default_nettype wire
